// [design/dram_mode_pkg.sv]
// Constants, field layout and carriers for the mode-register bank.
// Assumes a 10-bit column address and 8-bit mode registers.
package dram_mode_pkg;

   localparam int COL_W = 10;
   localparam int OP_W = 8;
   localparam int MA_W = 6;

   // Mode register addresses
   localparam logic [MA_W-1:0] MA_LATENCY = 6'h02;
   localparam logic [MA_W-1:0] MA_DRIVE = 6'h03;

   // Field positions, latency_and_leveling_config
   localparam int RL_LO = 0;
   localparam int WL_LO = 3;
   localparam int WLS_BIT = 6;
   localparam int WRLEV_BIT = 7;

   // Field positions, drive_and_inversion_config
   localparam int PUCAL_BIT = 0;
   localparam int WRPST_BIT = 1;
   localparam int PULL_DOWN_STRENGTH_LO = 3;
   localparam int DBIRD_BIT = 6;
   localparam int DBIWR_BIT = 7;

   localparam logic [OP_W-1:0] LATENCY_RESET = 8'h00;
   localparam logic [OP_W-1:0] DRIVE_RESET = 8'h30;
   // Repair-protection bit is stored but not decoded here and reads as zero
   localparam logic [OP_W-1:0] DRIVE_READ_MASK = 8'hFB;
   localparam logic [OP_W-1:0] UNMAPPED_READ = 8'h00;

   localparam logic [COL_W-1:0] LOW_COL_MASK = 10'h003;
   localparam logic [COL_W-1:0] COL23_MASK = 10'h00C;
   localparam logic [COL_W-1:0] BL16_MASK = 10'h00F;
   localparam logic [COL_W-1:0] BL32_MASK = 10'h01F;

   // Latency tables, index is the 3-bit code
   localparam logic [7:0][5:0] RL_PLAIN =
      {6'h24, 6'h20, 6'h1C, 6'h18, 6'h14, 6'h0E, 6'h0A, 6'h06};
   localparam logic [7:0][5:0] RL_INVERT =
      {6'h28, 6'h24, 6'h20, 6'h1C, 6'h16, 6'h10, 6'h0C, 6'h06};
   localparam logic [7:0][4:0] RTP_TABLE =
      {5'h10, 5'h0E, 5'h0C, 5'h0A, 5'h08, 5'h08, 5'h08, 5'h08};
   localparam logic [7:0][5:0] WL_SET_A =
      {6'h12, 6'h10, 6'h0E, 6'h0C, 6'h0A, 6'h08, 6'h06, 6'h04};
   localparam logic [7:0][5:0] WL_SET_B =
      {6'h22, 6'h1E, 6'h1A, 6'h16, 6'h12, 6'h0C, 6'h08, 6'h04};

   typedef enum logic [1:0] {CMD_MRW, CMD_MRR, CMD_WRITE, CMD_OTHER}
      cmd_kind_t;

   typedef struct packed {
      cmd_kind_t kind;
      logic [MA_W-1:0] addr;
      logic [OP_W-1:0] op;
      logic [COL_W-1:0] col;
      logic bl32;
   } cmd_t;

   typedef struct packed {
      logic [5:0] read_latency;
      logic [4:0] read_to_precharge_cycles;
      logic [5:0] write_latency;
      logic write_leveling;
      logic pull_up_cal_point;
      logic write_postamble_length;
      logic [2:0] pull_down_strength;
      logic read_inversion_enable;
      logic write_inversion_enable;
   } cfg_t;

endpackage : dram_mode_pkg

// [design/dram_latency_mode_regs.sv]
// Mode-register bank with latency decode, set points and write-burst
// column alignment. Commands arrive on the controller's link clock and
// are executed on CLOCK; set-point selects come from CLOCK-domain logic.
`timescale 1ns/1ps

module cmd_fifo
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
)
(
   input wire logic clk, // Core clock
   input wire logic rst_n, // Async reset, active low
   input wire logic ce, // Clock enable
   input wire logic in_valid, // Word offered
   output logic in_ready, // Room for a word
   input wire logic [WIDTH-1:0] in_data, // Word in
   output logic out_valid, // Word available
   input wire logic out_ready, // Consumer takes word
   output logic [WIDTH-1:0] out_data // Oldest word
);
   localparam int AW = $clog2(DEPTH);

   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
   begin : g_bad_depth
      $error("cmd_fifo depth must be a power of two");
   end

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_ptr;
   logic [AW:0] rd_ptr;

   wire full = (wr_ptr[AW] != rd_ptr[AW]) &&
      (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
   wire empty = wr_ptr == rd_ptr;
   wire push = ce && in_valid && !full;
   wire pop = ce && out_ready && !empty;

   assign in_ready = !full;
   assign out_valid = !empty;
   assign out_data = mem[rd_ptr[AW-1:0]];

   always_ff @(posedge clk)
   begin
      if (push)
         mem[wr_ptr[AW-1:0]] <= in_data;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end
      else
      begin
         if (push)
            wr_ptr <= wr_ptr + 1'b1;
         if (pop)
            rd_ptr <= rd_ptr + 1'b1;
      end
   end
endmodule : cmd_fifo

// Function
// RULE1: Sixteen-beat write bursts start on a sixteen-column boundary, sequential.
// RULE2: Thirty-two-beat write bursts start on a thirty-two-column boundary.
// RULE3: Lowest two column bits are always taken as zero.
// RULE4: Controller sends column bits two and three as zero on writes.
// RULE5: Latency register sits at address 02h, drive register at 03h.
// RULE6: Plain read latency table decodes bits 2:0 with precharge spacing.
// RULE7: Read inversion enabled selects the alternate read latency table.
// RULE8: Set select zero decodes bits 5:3 as write latency set A.
// RULE9: Set select one decodes bits 5:3 as write latency set B.
// RULE10: Bit 6 of latency register chooses write latency set.
// RULE11: Write leveling stays on until a register write clears it.
// RULE12: Controller sends only the leveling-clear write while leveling.
// RULE13: Register writes and reads use the write-selected set-point copy.
// RULE14: Operation follows only the operating-selected copy.
// RULE15: Drive bit 0 picks pull-up calibration point.
// RULE16: Drive bit 1 picks short or long write postamble.
// RULE17: Drive bits 5:3 pick pull-down strength; divide-by-six default.
// RULE18: Controller may pick sixteen or thirty-two beats per command.
// RULE19: Drive bit 7 enables write data-bus inversion.
module dram_latency_mode_regs
#(
   parameter int FIFO_DEPTH = 32
)
(
   input wire logic CLOCK, // Core clock, 100 MHz
   input wire logic RST_N, // Async reset, both domains
   input wire logic CE, // Core clock enable
   input wire logic LINK_CLK, // Controller-driven command clock
   input wire dram_mode_pkg::cmd_t CMD, // Command on link clock
   input wire logic CMD_VALID, // Command offered, link clock
   output logic CMD_READY, // Command accepted, link clock
   output logic MRR_VALID, // Register read answer pulse
   output logic [7:0] MRR_DATA, // Register read answer data
   input wire logic WRITE_SET_POINT, // Copy for writes and reads
   input wire logic OPERATING_SET_POINT, // Copy in operation
   output dram_mode_pkg::cfg_t CFG, // Decoded active settings
   output logic WR_BURST_VALID, // Write burst start pulse
   output logic [9:0] WR_BURST_COL, // Aligned start column
   output logic WR_BURST_BL32, // Burst is 32 beats
   output logic WR_COL_FAULT, // Column bits 3:2 were set
   output logic CMD_DROPPED // Command refused while leveling
);
   localparam int CMD_W = $bits(dram_mode_pkg::cmd_t);

   // Link-clock side
   dram_mode_pkg::cmd_t cmd_hold;
   logic req_tog;
   logic ack_s1;
   logic ack_s2;
   logic rep_s1;
   logic rep_s2;
   logic rep_s3;

   // Core side
   logic req_s1;
   logic req_s2;
   logic taken_tog;
   logic rpa_s1;
   logic rpa_s2;
   logic rep_tog;
   logic [7:0] rep_data;
   logic [7:0] lat_q [2];
   logic [7:0] drv_q [2];
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic [CMD_W-1:0] fifo_out_data;

   // Held command stays stable until the core has taken it
   wire link_pending = req_tog != ack_s2;
   assign CMD_READY = !link_pending;

   always_ff @(posedge LINK_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         cmd_hold <= '0;
         req_tog <= 1'b0;
         ack_s1 <= 1'b0;
         ack_s2 <= 1'b0;
      end
      else
      begin
         ack_s1 <= taken_tog;
         ack_s2 <= ack_s1;
         if (CMD_VALID && !link_pending)
         begin
            cmd_hold <= CMD;
            req_tog <= ~req_tog;
         end
      end
   end

   // Answer data is held by the core until rep_s3 returns
   wire rep_event = rep_s2 != rep_s3;

   always_ff @(posedge LINK_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         rep_s1 <= 1'b0;
         rep_s2 <= 1'b0;
         rep_s3 <= 1'b0;
         MRR_VALID <= 1'b0;
         MRR_DATA <= 8'h00;
      end
      else
      begin
         rep_s1 <= rep_tog;
         rep_s2 <= rep_s1;
         rep_s3 <= rep_s2;
         MRR_VALID <= rep_event;
         if (rep_event)
            MRR_DATA <= rep_data;
      end
   end

   // Core: crossing in, FIFO, execution
   wire in_pending = req_s2 != taken_tog;
   wire push = CE && in_pending && fifo_in_ready;
   wire reply_busy = rep_tog != rpa_s2;
   wire pop = CE && fifo_out_valid && !reply_busy;

   cmd_fifo #(.WIDTH(CMD_W), .DEPTH(FIFO_DEPTH)) u_fifo
   (
      .clk(CLOCK),
      .rst_n(RST_N),
      .ce(CE),
      .in_valid(in_pending),
      .in_ready(fifo_in_ready),
      .in_data(cmd_hold),
      .out_valid(fifo_out_valid),
      .out_ready(!reply_busy),
      .out_data(fifo_out_data)
   );

   dram_mode_pkg::cmd_t head;
   assign head = dram_mode_pkg::cmd_t'(fifo_out_data);

   wire [7:0] lat_act = lat_q[OPERATING_SET_POINT]; // RULE14
   wire [7:0] drv_act = drv_q[OPERATING_SET_POINT]; // RULE14
   wire leveling = lat_act[dram_mode_pkg::WRLEV_BIT];
   wire is_mrw = head.kind == dram_mode_pkg::CMD_MRW;
   wire to_lat = head.addr == dram_mode_pkg::MA_LATENCY; // RULE5
   wire to_drv = head.addr == dram_mode_pkg::MA_DRIVE; // RULE5
   wire lev_exit = is_mrw && to_lat &&
      !head.op[dram_mode_pkg::WRLEV_BIT];
   // Only the clearing write gets through while leveling
   wire drop = pop && leveling && !lev_exit; // RULE11
   wire exec = pop && !drop;
   wire wr_lat = exec && is_mrw && to_lat;
   wire wr_drv = exec && is_mrw && to_drv;
   wire do_mrr = exec && head.kind == dram_mode_pkg::CMD_MRR;
   wire do_write = exec && head.kind == dram_mode_pkg::CMD_WRITE;

   wire [7:0] read_sel = to_lat ? lat_q[WRITE_SET_POINT] : // RULE13
      to_drv ? (drv_q[WRITE_SET_POINT] &
      dram_mode_pkg::DRIVE_READ_MASK) : dram_mode_pkg::UNMAPPED_READ;

   wire [9:0] align_mask = head.bl32 ? dram_mode_pkg::BL32_MASK :
      dram_mode_pkg::BL16_MASK; // RULE1 RULE2
   wire [9:0] burst_col = head.col & ~align_mask &
      ~dram_mode_pkg::LOW_COL_MASK; // RULE3
   wire col_fault = (head.col & dram_mode_pkg::COL23_MASK) != '0; // RULE4

   // Two physical copies, written only through the write select
   for (genvar sp = 0; sp < 2; sp++)
   begin : g_set_point
      wire sel = WRITE_SET_POINT == 1'(sp); // RULE13
      always_ff @(posedge CLOCK or negedge RST_N)
      begin
         if (!RST_N)
         begin
            lat_q[sp] <= dram_mode_pkg::LATENCY_RESET;
            drv_q[sp] <= dram_mode_pkg::DRIVE_RESET;
         end
         else
         begin
            if (wr_lat && sel)
               lat_q[sp] <= head.op;
            if (wr_drv && sel)
               drv_q[sp] <= head.op;
         end
      end
   end

   // Decode from the operating copy only
   wire [2:0] rl_code = lat_act[dram_mode_pkg::RL_LO +: 3];
   wire [2:0] wl_code = lat_act[dram_mode_pkg::WL_LO +: 3];
   wire rd_inv = drv_act[dram_mode_pkg::DBIRD_BIT];
   wire wl_set_b = lat_act[dram_mode_pkg::WLS_BIT]; // RULE10
   dram_mode_pkg::cfg_t next_cfg;
   assign next_cfg.read_latency = rd_inv ?
      dram_mode_pkg::RL_INVERT[rl_code] : // RULE7
      dram_mode_pkg::RL_PLAIN[rl_code]; // RULE6
   assign next_cfg.read_to_precharge_cycles =
      dram_mode_pkg::RTP_TABLE[rl_code]; // RULE6
   assign next_cfg.write_latency = wl_set_b ?
      dram_mode_pkg::WL_SET_B[wl_code] : // RULE9
      dram_mode_pkg::WL_SET_A[wl_code]; // RULE8
   assign next_cfg.write_leveling = leveling; // RULE11
   assign next_cfg.pull_up_cal_point =
      drv_act[dram_mode_pkg::PUCAL_BIT]; // RULE15
   assign next_cfg.write_postamble_length =
      drv_act[dram_mode_pkg::WRPST_BIT]; // RULE16
   assign next_cfg.pull_down_strength =
      drv_act[dram_mode_pkg::PULL_DOWN_STRENGTH_LO +: 3]; // RULE17
   assign next_cfg.read_inversion_enable = rd_inv;
   assign next_cfg.write_inversion_enable =
      drv_act[dram_mode_pkg::DBIWR_BIT]; // RULE19

   always_ff @(posedge CLOCK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         req_s1 <= 1'b0;
         req_s2 <= 1'b0;
         rpa_s1 <= 1'b0;
         rpa_s2 <= 1'b0;
      end
      else if (CE)
      begin
         req_s1 <= req_tog;
         req_s2 <= req_s1;
         rpa_s1 <= rep_s3;
         rpa_s2 <= rpa_s1;
      end
   end

   always_ff @(posedge CLOCK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         taken_tog <= 1'b0;
         rep_tog <= 1'b0;
         rep_data <= 8'h00;
         CFG <= '0;
         WR_BURST_VALID <= 1'b0;
         WR_BURST_COL <= '0;
         WR_BURST_BL32 <= 1'b0;
         WR_COL_FAULT <= 1'b0;
         CMD_DROPPED <= 1'b0;
      end
      else if (CE)
      begin
         CFG <= next_cfg;
         WR_BURST_VALID <= do_write;
         WR_COL_FAULT <= do_write && col_fault;
         CMD_DROPPED <= drop;
         if (push)
            taken_tog <= ~taken_tog;
         if (do_write)
         begin
            WR_BURST_COL <= burst_col;
            WR_BURST_BL32 <= head.bl32;
         end
         if (do_mrr)
         begin
            rep_data <= read_sel;
            rep_tog <= ~rep_tog;
         end
      end
   end

   // Checks
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!RST_N);

   a_burst_align_16: assert property (
      WR_BURST_VALID && !WR_BURST_BL32 |-> WR_BURST_COL[3:0] == 4'h0)
      else $error("16-beat burst not aligned"); // RULE1
   a_burst_align_32: assert property (
      WR_BURST_VALID && WR_BURST_BL32 |-> WR_BURST_COL[4:0] == 5'h00)
      else $error("32-beat burst not aligned"); // RULE2
   a_write_upper_col: assert property (
      do_write |=> WR_BURST_COL[9:5] == $past(head.col[9:5]))
      else $error("burst column upper bits lost"); // RULE3
   a_rl_plain_decode: assert property (
      CE && !rd_inv |=> CFG.read_latency ==
      dram_mode_pkg::RL_PLAIN[$past(rl_code)])
      else $error("plain read latency wrong"); // RULE6
   a_rl_invert_decode: assert property (
      CE && rd_inv |=> CFG.read_latency ==
      dram_mode_pkg::RL_INVERT[$past(rl_code)] &&
      CFG.read_inversion_enable)
      else $error("inverted read latency wrong"); // RULE7
   a_wl_set_decode: assert property (
      CE |=> CFG.write_latency == ($past(wl_set_b) ?
      dram_mode_pkg::WL_SET_B[$past(wl_code)] :
      dram_mode_pkg::WL_SET_A[$past(wl_code)]))
      else $error("write latency wrong"); // RULE8 RULE9 RULE10
   a_leveling_drop: assert property (
      pop && leveling && !is_mrw |=> CMD_DROPPED && !WR_BURST_VALID)
      else $error("command accepted while leveling"); // RULE11
   a_copy_write: assert property (
      wr_drv |=> drv_q[$past(WRITE_SET_POINT)] == $past(head.op))
      else $error("selected copy not written"); // RULE13
   a_inactive_ignored: assert property (
      CE && wr_lat && WRITE_SET_POINT != OPERATING_SET_POINT &&
      !wr_drv ##1 CE && $stable(OPERATING_SET_POINT) |=>
      CFG == $past(CFG))
      else $error("inactive copy changed operation"); // RULE14
   a_mrr_answer: assert property (
      do_mrr && to_drv |=> rep_data ==
      (drv_q[$past(WRITE_SET_POINT)] & dram_mode_pkg::DRIVE_READ_MASK))
      else $error("register read answer wrong"); // RULE13
endmodule : dram_latency_mode_regs

// [verification/link_ctrl_model.sv]
// Memory-controller model: free-running command clock, one command at
// a time, and a queue of register read answers.
// Assumes the device takes a command on a clock edge with ready high.
`timescale 1ns/1ps

module link_ctrl_model
(
   output logic link_clk, // Command clock, 32 ns
   output dram_mode_pkg::cmd_t cmd, // Command word
   output logic cmd_valid, // Command offered
   input wire logic cmd_ready, // Device takes command
   input wire logic mrr_valid, // Read answer pulse
   input wire logic [7:0] mrr_data // Read answer data
);
   logic [7:0] answers[$];

   initial
   begin
      link_clk = 1'b0;
      cmd = '0;
      cmd_valid = 1'b0;
      #3;
      forever #16 link_clk = ~link_clk;
   end

   // Answer is a one-cycle pulse, so it is caught on exactly one rising edge
   always @(posedge link_clk)
      if (mrr_valid === 1'b1)
         answers.push_back(mrr_data);

   // Held until the edge that sees ready; released lines show inverse
   task automatic send(input dram_mode_pkg::cmd_t c, output bit ok);
      int n;
      ok = 1'b0;
      @(negedge link_clk);
      cmd = c;
      cmd_valid = 1'b1;
      for (n = 0; n < 200 && !ok; n++)
      begin
         @(posedge link_clk);
         ok = (cmd_ready === 1'b1);
      end
      // Released on the edge that took it, not half a cycle later
      cmd_valid <= 1'b0;
      cmd <= ~c;
   endtask : send
endmodule : link_ctrl_model

// [verification/testbench.sv]
// Self-checking bench for the mode-register bank with a reference model
// of both set-point copies. Assumes the controller model in link_ctrl_model.
`timescale 1ns/1ps

`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
$display("Error %0t: got %h exp %h", $time, g, e); end end

module testbench;
   logic clock, rst_n, ce, ce_jit, wsp, osp, link_clk, cmd_valid, cmd_ready;
   logic mrr_valid, wbv, wbb, wcf, drop;
   logic [7:0] mrr_data;
   logic [9:0] wbc, col;
   dram_mode_pkg::cmd_t cmd_w;
   dram_mode_pkg::cfg_t cfg;
   logic [7:0] lat[2], drv[2];
   logic [11:0] bursts[$];
   logic [11:0] got_b, exp_b;
   logic [5:0] rl_pl[8] = '{6'h06, 6'h0A, 6'h0E, 6'h14, 6'h18, 6'h1C,
      6'h20, 6'h24};
   logic [5:0] rl_inv[8] = '{6'h06, 6'h0C, 6'h10, 6'h16, 6'h1C, 6'h20,
      6'h24, 6'h28};
   logic [4:0] rtp[8] = '{5'h08, 5'h08, 5'h08, 5'h08, 5'h0A, 5'h0C,
      5'h0E, 5'h10};
   logic [5:0] wl_a[8] = '{6'h04, 6'h06, 6'h08, 6'h0A, 6'h0C, 6'h0E,
      6'h10, 6'h12};
   logic [5:0] wl_b[8] = '{6'h04, 6'h08, 6'h0C, 6'h12, 6'h16, 6'h1A,
      6'h1E, 6'h22};
   int n_checks = 0, n_mismatch = 0, n_drop = 0, seed, i, d0;
   logic b;

   initial
   begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   link_ctrl_model ctrl (.link_clk(link_clk), .cmd(cmd_w),
      .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
      .mrr_valid(mrr_valid), .mrr_data(mrr_data));

   dram_latency_mode_regs #(.FIFO_DEPTH(4)) uut (.CLOCK(clock),
      .RST_N(rst_n), .CE(ce), .LINK_CLK(link_clk), .CMD(cmd_w),
      .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready), .MRR_VALID(mrr_valid),
      .MRR_DATA(mrr_data), .WRITE_SET_POINT(wsp),
      .OPERATING_SET_POINT(osp), .CFG(cfg), .WR_BURST_VALID(wbv),
      .WR_BURST_COL(wbc), .WR_BURST_BL32(wbb), .WR_COL_FAULT(wcf),
      .CMD_DROPPED(drop));

   // Clock enable stalls the core at random only while ce_jit is set
   always @(negedge clock)
      ce <= ce_jit ? 1'($random(seed)) : 1'b1;

   // Pulses stand until the next enabled edge, so count only there
   always @(posedge clock)
   begin
      if (ce === 1'b1 && wbv === 1'b1)
         bursts.push_back({wcf, wbb, wbc});
      if (ce === 1'b1 && drop === 1'b1)
         n_drop++;
   end

   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : close_out

   task automatic fail();
      n_mismatch++;
      $display("Error %0t: handshake timed out", $time);
      close_out();
   endtask : fail

   function automatic dram_mode_pkg::cfg_t exp_cfg();
      dram_mode_pkg::cfg_t e;
      logic [7:0] l, d;
      l = lat[osp];
      d = drv[osp];
      e.read_latency = d[6] ? rl_inv[l[2:0]] : rl_pl[l[2:0]];
      e.read_to_precharge_cycles = rtp[l[2:0]];
      e.write_latency = l[6] ? wl_b[l[5:3]] : wl_a[l[5:3]];
      e.write_leveling = l[7];
      e.pull_up_cal_point = d[0];
      e.write_postamble_length = d[1];
      e.pull_down_strength = d[5:3];
      e.read_inversion_enable = d[6];
      e.write_inversion_enable = d[7];
      return e;
   endfunction : exp_cfg

   task automatic cmd(dram_mode_pkg::cmd_kind_t k, logic [5:0] a,
      logic [7:0] o, logic [9:0] c, logic bl);
      bit ok;
      int n;
      ctrl.send({k, a, o, c, bl}, ok);
      n = 0;
      do
      begin
         @(posedge link_clk);
         n++;
      end while (n < 200 && cmd_ready !== 1'b1);
      if (!ok || cmd_ready !== 1'b1)
         fail();
      repeat (24) @(posedge clock);
   endtask : cmd

   task automatic mrw(logic [5:0] a, logic [7:0] o);
      cmd(dram_mode_pkg::CMD_MRW, a, o, 10'h000, 1'b0);
      if (a == dram_mode_pkg::MA_LATENCY)
         lat[wsp] = o;
      if (a == dram_mode_pkg::MA_DRIVE)
         drv[wsp] = o;
   endtask : mrw

   task automatic mrr_chk(logic [5:0] a, logic [7:0] e);
      int n;
      logic [7:0] g;
      cmd(dram_mode_pkg::CMD_MRR, a, 8'h00, 10'h000, 1'b0);
      for (n = 0; n < 100 && ctrl.answers.size() == 0; n++)
         @(posedge link_clk);
      if (n == 100)
         fail();
      g = ctrl.answers.pop_front();
      `CHK(g, e)
   endtask : mrr_chk

   task automatic chk_all();
      `CHK(cfg, exp_cfg())
      mrr_chk(dram_mode_pkg::MA_LATENCY, lat[wsp]);
      mrr_chk(dram_mode_pkg::MA_DRIVE, drv[wsp] & 8'hFB);
   endtask : chk_all

   task automatic set_sp(logic w, logic o);
      @(negedge clock);
      wsp = w;
      osp = o;
      repeat (4) @(posedge clock);
   endtask : set_sp

   initial
   begin
      #900000;
      fail();
   end

   initial
   begin
      seed = 32'h1494DDDF;
      rst_n = 1'b0;
      ce_jit = 1'b0;
      wsp = 1'b0;
      osp = 1'b0;
      lat = '{8'h00, 8'h00};
      drv = '{8'h30, 8'h30};
      // Long enough for two edges of the slower link clock
      repeat (7) @(negedge clock);
      rst_n = 1'b1;
      repeat (4) @(posedge clock);
      chk_all();
      mrw(6'h05, 8'hFF);
      mrr_chk(6'h05, 8'h00);
      $display("test reset done");
      for (i = 0; i < 16; i++)
      begin
         mrw(dram_mode_pkg::MA_LATENCY, {1'b0, i[3], i[2:0], ~i[2:0]});
         mrw(dram_mode_pkg::MA_DRIVE, 8'($random(seed)));
         chk_all();
      end
      $display("test latency done");
      ce_jit = 1'b1;
      for (i = 0; i < 24; i++)
      begin
         col = 10'($random(seed));
         b = 1'($random(seed));
         cmd(dram_mode_pkg::CMD_WRITE, 6'h00, 8'h00, col, b);
         `CHK(bursts.size(), 1)
         exp_b = {|col[3:2], b, col & ~(b ? 10'h01F : 10'h00F)};
         got_b = bursts.pop_front();
         `CHK(got_b, exp_b)
      end
      ce_jit = 1'b0;
      $display("test bursts done");
      mrw(dram_mode_pkg::MA_LATENCY, lat[0] | 8'h80);
      `CHK(cfg, exp_cfg())
      d0 = n_drop;
      cmd(dram_mode_pkg::CMD_WRITE, 6'h00, 8'h00, 10'h040, 1'b0);
      cmd(dram_mode_pkg::CMD_MRR, dram_mode_pkg::MA_DRIVE, 8'h00,
         10'h000, 1'b0);
      cmd(dram_mode_pkg::CMD_MRW, dram_mode_pkg::MA_DRIVE, 8'h00,
         10'h000, 1'b0);
      cmd(dram_mode_pkg::CMD_OTHER, 6'h00, 8'h00, 10'h000, 1'b0);
      `CHK(n_drop - d0, 4)
      `CHK(bursts.size() + ctrl.answers.size(), 0)
      mrw(dram_mode_pkg::MA_LATENCY, lat[0] & 8'h7F);
      chk_all();
      $display("test leveling done");
      set_sp(1'b1, 1'b0);
      mrw(dram_mode_pkg::MA_LATENCY, 8'h7F);
      mrw(dram_mode_pkg::MA_DRIVE, 8'hC9);
      chk_all();
      set_sp(1'b1, 1'b1);
      chk_all();
      set_sp(1'b0, 1'b1);
      mrw(dram_mode_pkg::MA_LATENCY, 8'h12);
      chk_all();
      $display("test set points done");
      close_out();
   end
endmodule : testbench
